//--- shared/sac_pkg.sv
// Constants, state codes and timing figures for the SAR conversion control block.
// Assumes a single 100 MHz core clock; the converter clock is an enable derived from it.
package sac_pkg;

	localparam int SAC_WIDTH = 8;

	// Approximation register values.
	localparam logic [7:0] SAC_SAR_RESET = 8'h00;
	localparam logic [7:0] SAC_SAR_START = 8'h80;

	// Bit positions under test.
	localparam logic [2:0] SAC_IDX_MSB = 3'h7;
	localparam logic [2:0] SAC_IDX_LSB = 3'h0;
	localparam logic [2:0] SAC_IDX_STEP = 3'h1;

	// Synchroniser lanes and their idle levels.
	localparam int SAC_SYNC_W = 3;
	localparam int SAC_IN_CONV = 0;
	localparam int SAC_IN_RD = 1;
	localparam int SAC_IN_CMP = 2;
	localparam logic [2:0] SAC_SYNC_RST = 3'h3;

	// Core clock and the least settle time of the MSB trial before its decision.
	localparam int SAC_CORE_PERIOD_NS = 10;
	localparam int SAC_SETTLE_MIN_NS = 550;
	localparam int SAC_SETTLE_MIN_CYC =
		(SAC_SETTLE_MIN_NS + SAC_CORE_PERIOD_NS - 1) / SAC_CORE_PERIOD_NS;

	// Converter clock half period equals the settle time, so rise-then-fall always covers it.
	localparam int SAC_CONV_HALF_CYC = SAC_SETTLE_MIN_CYC;
	localparam int SAC_DIV_W = 6;
	localparam logic [5:0] SAC_DIV_ZERO = 6'h00;
	localparam logic [5:0] SAC_DIV_ONE = 6'h01;
	localparam logic [5:0] SAC_DIV_LAST = 6'(SAC_CONV_HALF_CYC - 1);

	typedef enum logic [1:0] {
		SAC_ST_IDLE = 2'b00,
		SAC_ST_CLEAR = 2'b01,
		SAC_ST_ARM = 2'b10,
		SAC_ST_RUN = 2'b11
	} sac_state_t;

endpackage

//--- hw/sac_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs may change at any time relative to core_clk_in.
`timescale 1ns/1ps
module sac_sync
	import sac_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [SAC_SYNC_W-1:0] pin_in,
	output logic [SAC_SYNC_W-1:0] level_out
);

	logic [SAC_SYNC_W-1:0] meta_r;
	logic [SAC_SYNC_W-1:0] s2_r;
	logic [SAC_SYNC_W-1:0] s3_r;
	logic [SAC_SYNC_W-1:0] level_r;
	logic [SAC_SYNC_W-1:0] level_nxt;

	// A lane only moves once the second and third stages agree, filtering a late-settling edge.
	always_comb begin
		for (int i = 0; i < SAC_SYNC_W; i++) begin
			level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_r[i];
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= SAC_SYNC_RST;
			s2_r <= SAC_SYNC_RST;
			s3_r <= SAC_SYNC_RST;
			level_r <= SAC_SYNC_RST;
		end else begin
			meta_r <= pin_in;
			s2_r <= meta_r;
			s3_r <= s2_r;
			level_r <= level_nxt;
		end
	end

	assign level_out = level_r;

endmodule

//--- hw/sac_clkdiv.sv
// Converter clock divider producing one-cycle rise and fall enables.
// Assumes the core clock is the only clock; the converter clock exists as enables and as the conv_clk_out level.
`timescale 1ns/1ps
module sac_clkdiv
	import sac_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	output logic rise_en_out,
	output logic fall_en_out,
	output logic conv_clk_out
);

	logic [SAC_DIV_W-1:0] cnt_r;
	logic [SAC_DIV_W-1:0] cnt_nxt;
	logic level_r;
	logic level_nxt;
	logic rise_r;
	logic rise_nxt;
	logic fall_r;
	logic fall_nxt;

	always_comb begin
		cnt_nxt = cnt_r + SAC_DIV_ONE;
		level_nxt = level_r;
		rise_nxt = 1'b0;
		fall_nxt = 1'b0;
		if (cnt_r == SAC_DIV_LAST) begin
			cnt_nxt = SAC_DIV_ZERO;
			level_nxt = ~level_r;
			rise_nxt = ~level_r;
			fall_nxt = level_r;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= SAC_DIV_ZERO;
			level_r <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			level_r <= level_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
		end
	end

	assign rise_en_out = rise_r;
	assign fall_en_out = fall_r;
	assign conv_clk_out = level_r;

endmodule

//--- hw/sac_top.sv
// Digital control of an 8-bit successive-approximation converter.
// Assumes an external comparator reports whether the input lies above dac_code_out, and an
// external party drives the active-low convert and read pins asynchronously.
`timescale 1ns/1ps
module sac_top
	import sac_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic convert_n_in,
	input wire logic rd_n_in,
	input wire logic cmp_above_in,
	output logic busy_n_out,
	output logic [SAC_WIDTH-1:0] data_out,
	output logic [SAC_WIDTH-1:0] data_oe_n_out,
	output logic [SAC_WIDTH-1:0] dac_code_out,
	output logic conv_clk_out
);

	logic [SAC_SYNC_W-1:0] pins;
	logic [SAC_SYNC_W-1:0] pins_sync;
	logic convert_n;
	logic rd_n;
	logic cmp_above;
	logic rise_en;
	logic fall_en;
	logic conv_clk;

	sac_state_t state_r;
	sac_state_t state_nxt;
	logic [SAC_WIDTH-1:0] sar_r;
	logic [SAC_WIDTH-1:0] sar_nxt;
	logic [2:0] idx_r;
	logic [2:0] idx_nxt;
	logic busy_n_r;
	logic busy_n_nxt;
	logic [SAC_WIDTH-1:0] oe_n_r;
	logic [SAC_WIDTH-1:0] oe_n_nxt;
	logic conv_clk_r;
	logic decide;
	logic [SAC_WIDTH-1:0] test_mask;
	logic [SAC_WIDTH-1:0] trial_mask;

	// One-hot decode of a bit position, used for the bit under test and for the next trial.
	function automatic logic [SAC_WIDTH-1:0] sac_onehot(input logic [2:0] pos);
		logic [SAC_WIDTH-1:0] m;
		m = SAC_SAR_RESET;
		m[pos] = 1'b1;
		return m;
	endfunction

	// The request, the read enable and the comparator all come from outside the core domain.
	assign pins[SAC_IN_CONV] = convert_n_in;
	assign pins[SAC_IN_RD] = rd_n_in;
	assign pins[SAC_IN_CMP] = cmp_above_in;

	sac_sync u_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.pin_in(pins),
		.level_out(pins_sync)
	);

	assign convert_n = pins_sync[SAC_IN_CONV];
	assign rd_n = pins_sync[SAC_IN_RD];
	assign cmp_above = pins_sync[SAC_IN_CMP];

	sac_clkdiv u_div (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.rise_en_out(rise_en),
		.fall_en_out(fall_en),
		.conv_clk_out(conv_clk)
	);

	// A decision is only made on a converter falling edge while running.
	assign decide = (state_r == SAC_ST_RUN) && fall_en;
	assign test_mask = sac_onehot(idx_r);
	// At the LSB there is no lower bit; the decode wraps but is masked off below.
	assign trial_mask = sac_onehot(idx_r - SAC_IDX_STEP);

	// Sequencer. A low request overrides every state, so a pulse is never locked out.
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		busy_n_nxt = busy_n_r;
		if (!convert_n) begin
			state_nxt = SAC_ST_CLEAR;
			idx_nxt = SAC_IDX_MSB;
			busy_n_nxt = 1'b0;
		end else begin
			unique case (state_r)
				SAC_ST_IDLE: begin
					state_nxt = SAC_ST_IDLE;
				end
				SAC_ST_CLEAR: begin
					// Release seen; the MSB trial has been presented since the request fell.
					state_nxt = SAC_ST_ARM;
				end
				SAC_ST_ARM: begin
					// Waiting for a rising edge guarantees a full half period of MSB settling.
					if (rise_en) begin
						state_nxt = SAC_ST_RUN;
					end
				end
				SAC_ST_RUN: begin
					if (fall_en) begin
						if (idx_r == SAC_IDX_LSB) begin
							state_nxt = SAC_ST_IDLE;
							busy_n_nxt = 1'b1;
						end else begin
							idx_nxt = idx_r - SAC_IDX_STEP;
						end
					end
				end
			endcase
		end
	end

	// Approximation register, one decision lane per bit.
	for (genvar b = 0; b < SAC_WIDTH; b++) begin : g_bit
		always_comb begin
			sar_nxt[b] = sar_r[b];
			if (!convert_n) begin
				sar_nxt[b] = SAC_SAR_START[b];
			end else if (decide) begin
				if (test_mask[b]) begin
					sar_nxt[b] = cmp_above;
				end else if (trial_mask[b] && (idx_r != SAC_IDX_LSB)) begin
					sar_nxt[b] = 1'b1;
				end
			end
		end
	end

	// Output enables follow the read pin only; nothing here feeds back into the register.
	always_comb begin
		oe_n_nxt = {SAC_WIDTH{rd_n}};
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= SAC_ST_IDLE;
			sar_r <= SAC_SAR_RESET;
			idx_r <= SAC_IDX_MSB;
			busy_n_r <= 1'b1;
			oe_n_r <= {SAC_WIDTH{1'b1}};
			conv_clk_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sar_r <= sar_nxt;
			idx_r <= idx_nxt;
			busy_n_r <= busy_n_nxt;
			oe_n_r <= oe_n_nxt;
			conv_clk_r <= conv_clk;
		end
	end

	// Data and busy update on the same edge, so enabled outputs show the result as busy rises.
	assign data_out = sar_r;
	assign dac_code_out = sar_r;
	assign busy_n_out = busy_n_r;
	assign data_oe_n_out = oe_n_r;
	assign conv_clk_out = conv_clk_r;

endmodule

//--- verification/sac_top_props.sv
// Checker on the conversion control ports.
// Assumes one core clock domain and the active-high reset.
`timescale 1ns/1ps
module sac_top_props (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic convert_n_in,
	input wire logic rd_n_in,
	input wire logic cmp_above_in,
	input wire logic busy_n_out,
	input wire logic [7:0] data_out,
	input wire logic [7:0] data_oe_n_out,
	input wire logic [7:0] dac_code_out,
	input wire logic conv_clk_out
);
	// Cycles since the register last moved, saturating. A decision that comes too soon
	// after the trial code was loaded means the MSB trial was not given time to settle.
	logic [7:0] gap_r;
	logic [7:0] seen_r;
	always_ff @(posedge core_clk_in) begin
		seen_r <= data_out;
		if (rst_in || data_out != seen_r) begin
			gap_r <= 8'h00;
		end else if (gap_r != 8'hFF) begin
			gap_r <= gap_r + 8'h01;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_start_code: assert property ($fell(busy_n_out) |-> data_out == 8'h80)
		else $error("start code wrong");
	a_dac_mirror: assert property (dac_code_out == data_out)
		else $error("dac code differs from register");
	a_idle_stable: assert property (busy_n_out && $past(busy_n_out) |-> $stable(data_out))
		else $error("register changed while idle");
	a_oe_uniform: assert property (data_oe_n_out == 8'h00 || data_oe_n_out == 8'hFF)
		else $error("enables split");
	a_oe_off: assert property ($rose(rd_n_in) |-> ##[2:7] data_oe_n_out == 8'hFF)
		else $error("outputs not floated");
	a_oe_on: assert property ($fell(rd_n_in) |-> ##[2:7] data_oe_n_out == 8'h00)
		else $error("outputs not driven");
	a_hold_clear: assert property (!convert_n_in [*8] |-> data_out == 8'h80 && !busy_n_out)
		else $error("held request did not clear");
	a_busy_edge: assert property ($rose(busy_n_out) |-> ##2 !conv_clk_out && $past(conv_clk_out, 5))
		else $error("busy rise off the falling edge");
	a_one_step: assert property (!busy_n_out && $changed(data_out) && data_out != 8'h80 |-> $countones(data_out ^ $past(data_out)) <= 2)
		else $error("more than one bit step");
	a_msb_settle: assert property (!busy_n_out && $changed(data_out) && data_out != 8'h80 |-> gap_r >= 8'h37)
		else $error("decision before the trial settled");
endmodule
bind sac_top sac_top_props u_props (.core_clk_in, .rst_in, .convert_n_in, .rd_n_in,
	.cmp_above_in, .busy_n_out, .data_out, .data_oe_n_out, .dac_code_out, .conv_clk_out);

//--- verification/sac_far_model.sv
// Far side: comparator on the trial code and the convert source.
// Assumes start_in is a bench pulse and free_in selects feedback.
`timescale 1ns/1ps
module sac_far_model (
	input wire logic busy_n_in,
	input wire logic [7:0] dac_code_in,
	input wire logic [7:0] vin_in,
	input wire logic start_in,
	input wire logic free_in,
	output logic convert_n_out,
	output logic cmp_above_out
);
	// A level equal to the trial counts as above, so a result equals vin_in.
	assign cmp_above_out = vin_in >= dac_code_in;
	// The NOR form restarts a conversion whenever busy is high, so the loop needs no start pulse after reset.
	assign convert_n_out = free_in ? !(busy_n_in || start_in) : !start_in;
endmodule

//--- verification/tb_sac_top.sv
// Bench for the conversion control block with the far-side model.
// Assumes the design's 110-cycle converter clock.
`timescale 1ns/1ps
module tb_sac_top;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic rd_n_in = 1'b1;
	logic start = 1'b0;
	logic free = 1'b0;
	logic [7:0] vin = 8'h00;
	logic convert_n_in, cmp_above_in, busy_n_out, conv_clk_out;
	logic [7:0] data_out, data_oe_n_out, dac_code_out;
	int n_mismatch = 0;
	int check_count = 0;
	int dur;
	logic [15:0] rows [4] = '{16'h0000, 16'hFFFF, 16'h5A5A, 16'hA5A5};
	sac_top dut (.core_clk_in, .rst_in, .convert_n_in, .rd_n_in, .cmp_above_in,
		.busy_n_out, .data_out, .data_oe_n_out, .dac_code_out, .conv_clk_out);
	sac_far_model far (.busy_n_in(busy_n_out), .dac_code_in(dac_code_out), .vin_in(vin),
		.start_in(start), .free_in(free), .convert_n_out(convert_n_in),
		.cmp_above_out(cmp_above_in));
	initial begin
		forever #5 core_clk_in = ~core_clk_in;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic wait_busy(input logic lvl, inout int n);
		while (busy_n_out !== lvl && n < 3000) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic convert();
		start = 1'b1;
		cyc(20);
		chk(data_out, 8'h80);
		chk(dac_code_out, 8'h80);
		chk({7'h00, busy_n_out}, 8'h00);
		start = 1'b0;
		dur = 0;
		wait_busy(1'b1, dur);
		chk(8'(dur >= 820 && dur <= 950), 8'h01);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		cyc(12);
		chk({7'h00, busy_n_out}, 8'h01);
		chk(data_out, 8'h00);
		chk(data_oe_n_out, 8'hFF);
		rst_in = 1'b0;
		$display("reset test done");
		foreach (rows[i]) begin
			vin = rows[i][15:8];
			convert();
			chk(data_out, rows[i][7:0]);
			$display("conversion %0d done", i);
		end
		rd_n_in = 1'b0;
		cyc(8);
		chk(data_oe_n_out, 8'h00);
		cyc(200);
		chk(data_out, 8'hA5);
		$display("read test done");
		vin = 8'h3C;
		start = 1'b1;
		cyc(20);
		start = 1'b0;
		cyc(300);
		convert();
		chk(data_out, 8'h3C);
		chk(data_oe_n_out, 8'h00);
		$display("abort test done");
		rd_n_in = 1'b1;
		free = 1'b1;
		dur = 0;
		wait_busy(1'b0, dur);
		wait_busy(1'b1, dur);
		dur = 0;
		wait_busy(1'b0, dur);
		wait_busy(1'b1, dur);
		chk(8'(dur >= 870 && dur <= 890), 8'h01);
		chk(data_out, 8'h3C);
		$display("free run test done");
		end_of_test();
	end
	initial begin
		#150us;
		n_mismatch++;
		end_of_test();
	end
endmodule
